/* include/lcdid_consts.vh */
// constants for the lcd instruction decoder: opcodes, masks, reset values, timing
// assumes plain verilog-2005 includes by bare name
`ifndef LCDID_CONSTS_VH
`define LCDID_CONSTS_VH
// ****************************************
// instruction codes and compare masks
// ****************************************
`define LCDID_OP_DISP 8'hae
`define LCDID_MK_DISP 8'hfe
`define LCDID_OP_LINE 8'h40
`define LCDID_MK_LINE 8'hc0
`define LCDID_OP_PAGE 8'hb0
`define LCDID_OP_COLH 8'h10
`define LCDID_OP_COLL 8'h00
`define LCDID_MK_NIB 8'hf0
`define LCDID_OP_SEGD 8'ha0
`define LCDID_OP_INV 8'ha6
`define LCDID_OP_ALL 8'ha4
`define LCDID_OP_BIAS 8'ha2
`define LCDID_MK_BIT0 8'hfe
`define LCDID_OP_MRD 8'he0
`define LCDID_OP_MRDEND 8'hee
`define LCDID_OP_RST 8'he2
`define LCDID_OP_NOP 8'he3
`define LCDID_MK_ALL 8'hff
`define LCDID_OP_SCAN 8'hc0
`define LCDID_OP_PWR 8'h28
`define LCDID_OP_RSEL 8'h20
`define LCDID_MK_LOW3 8'hf8
`define LCDID_OP_CONTR 8'h81
`define LCDID_OP_IND 8'hac
`define LCDID_OP_TEST1 8'hf0
`define LCDID_OP_TEST2 8'h90
// ****************************************
// reset values and limits
// ****************************************
`define LCDID_CONTRAST_RST 6'h20
`define LCDID_RSEL_RST 3'h4
`define LCDID_COL_MAX 8'h83
// ****************************************
// timing, clock at 125 mhz
// ****************************************
`define LCDID_CLK_MHZ 125
`define LCDID_HRST_NS 1000
`define LCDID_IRST_NS 200
`endif

/* rtl/lcdid_decoder.v */
// lcd instruction decoder: host instruction port, display state, write fifo, ram port
// assumes host strobes come from logic on CLOCK; duty and reset pins are asynchronous
//
// Notes on behaviour
// [R1] display on/off command bit 0 switches panel drive on or off
// [R2] initial line command loads six-bit top display line
// [R3] page command loads four-bit page, display unaffected
// [R4] column loaded by upper and lower nibble commands, 0 to 131; the nibble commands load any value up to 255
// [R5] each display data write advances column by one, holding at 131
// [R6] status byte: busy, direction, display, reset flag, low nibble zero
// [R7] busy during reset or internal work; other instructions then rejected
// [R8] display flag 0 means on; direction flag 1 means normal
// [R9] reset flag reads 1 while pin-triggered initialisation runs
// [R10] data write stores byte at current page and column
// [R11] data read returns ram byte then advances column; host does dummy read
// [R12] data reads refused while serial host interface is used
// [R13] segment direction bit reverses column driver order
// [R14] invert bit swaps lit and dark pixels, ram untouched
// [R15] all-pixels-on forces every pixel on, overriding invert
// [R16] bias bit with duty pins selects bias ratio
// [R17] modify-read mode: reads hold column, writes still advance
// [R18] end modify-read restores column saved on entry
// [R19] reset instruction clears line, column, page, scan; keeps ram and power
// [R20] scan command bit 3 selects row scan direction
// [R21] power command loads converter, regulator, follower enables
// [R22] nop changes nothing; test codes cleared by either reset
// [R23] contrast mode entry then byte loads six-bit contrast; mode ends
// [R24] indicator mode on, next byte loads two-bit blink code; mode ends
// [R25] all-on while display off enters standby or sleep; all-on off leaves
// [R26] during reset only status reads are accepted
// [R27] unknown command bytes change nothing
`timescale 1ns/1ps
`include "lcdid_consts.vh"

// ****************************************
// write buffer
// ****************************************
module lcdid_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // lcdid_fifo

// ****************************************
// decoder top
// ****************************************
module lcdid_decoder #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // clock and reset
  input wire CLOCK,
  input wire RESETN,
  // pins from outside the clock domain
  input wire HARD_RESET_LOW,
  input wire [1:0] DUTY_RATIO_PINS,
  // host instruction port
  input wire HOST_REQ,
  input wire COMMAND_DATA_SELECT,
  input wire READ_SELECT,
  input wire SERIAL_MODE,
  input wire [7:0] HOST_WDATA,
  output reg [7:0] HOST_RDATA,
  output reg HOST_RVALID,
  output reg HOST_REJECT,
  output wire HOST_BUSY,
  // display ram port
  output wire RAM_WE,
  input wire RAM_WREADY,
  output wire [3:0] RAM_WPAGE,
  output wire [7:0] RAM_WCOL,
  output wire [7:0] RAM_WDATA,
  output reg RAM_RE,
  output reg [3:0] RAM_RPAGE,
  output reg [7:0] RAM_RCOL,
  input wire RAM_RVALID,
  input wire [7:0] RAM_RDATA,
  // display state
  output reg DISPLAY_ON,
  output reg [5:0] TOP_LINE_SELECT,
  output reg [3:0] PAGE_FIELD,
  output reg [7:0] COLUMN_FIELD,
  output reg COLUMN_DRIVER_REVERSE,
  output reg ROW_SCAN_REVERSE,
  output reg INVERT_PIXELS,
  output reg ALL_PIXELS_ON,
  output reg PIXEL_INVERT_EFFECTIVE,
  output reg [3:0] BIAS_DENOMINATOR,
  // power and contrast
  output reg CONVERTER_ENABLE,
  output reg REGULATOR_ENABLE,
  output reg FOLLOWER_ENABLE,
  output reg [2:0] REGULATOR_RATIO,
  output reg [5:0] CONTRAST_LEVEL,
  output reg INDICATOR_MODE_ON,
  output reg [1:0] INDICATOR_BLINK_CODE,
  output reg POWER_SAVE_SLEEP,
  output reg POWER_SAVE_STANDBY,
  output reg TEST_MODE
);
  localparam HRST_CYC = (`LCDID_HRST_NS * `LCDID_CLK_MHZ + 999) / 1000;
  localparam IRST_CYC = (`LCDID_IRST_NS * `LCDID_CLK_MHZ + 999) / 1000;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CONTR = 3'b010;
  localparam [2:0] ST_IND = 3'b100;

  function match;
    input [7:0] b;
    input [7:0] op;
    input [7:0] mk;
    begin
      match = ((b & mk) == op);
    end
  endfunction

  function [7:0] col_next;
    input [7:0] c;
    begin
      col_next = (c == `LCDID_COL_MAX) ? c : c + 8'h01;
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg hrst_meta_q;
  reg hrst_s2_q;
  reg [1:0] duty_meta_q;
  reg [1:0] duty_s2_q;
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      hrst_meta_q <= 1'b0;
      hrst_s2_q <= 1'b0;
      duty_meta_q <= 2'h0;
      duty_s2_q <= 2'h0;
    end else begin
      hrst_meta_q <= HARD_RESET_LOW;
      hrst_s2_q <= hrst_meta_q;
      duty_meta_q <= DUTY_RATIO_PINS;
      duty_s2_q <= duty_meta_q;
    end
  end

  // ****************************************
  // reset sequencing and busy
  // ****************************************
  reg [7:0] hcnt_q;
  reg [7:0] icnt_q;
  reg rd_pend_q;
  wire hrst_busy;
  wire irst_busy;
  wire busy;
  wire fifo_in_ready;
  wire fifo_out_valid;
  assign hrst_busy = ~hrst_s2_q | (hcnt_q != 8'h00); // R9
  assign irst_busy = (icnt_q != 8'h00);
  assign busy = hrst_busy | irst_busy | rd_pend_q | ~fifo_in_ready; // R7
  assign HOST_BUSY = busy;

  wire take = HOST_REQ;
  wire is_stat = ~COMMAND_DATA_SELECT & READ_SELECT;
  wire is_cmd = ~COMMAND_DATA_SELECT & ~READ_SELECT;
  wire is_wr = COMMAND_DATA_SELECT & ~READ_SELECT;
  wire is_rd = COMMAND_DATA_SELECT & READ_SELECT;
  // reads must see every buffered write first, so they are refused until the fifo is empty
  wire accept = take & ~is_stat & ~busy & ~(is_rd & (SERIAL_MODE | fifo_out_valid)); // R26 R12
  wire cmd_ok = accept & is_cmd;
  wire [7:0] b = HOST_WDATA;

  // ****************************************
  // write buffer instance
  // ****************************************
  wire [19:0] fifo_out;
  lcdid_fifo #(.WIDTH(20), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(CLOCK),
    .rst_n(RESETN),
    .in_valid(accept & is_wr),
    .in_ready(fifo_in_ready),
    .in_data({PAGE_FIELD, COLUMN_FIELD, b}), // R10
    .out_valid(fifo_out_valid),
    .out_ready(RAM_WREADY),
    .out_data(fifo_out)
  );
  assign RAM_WE = fifo_out_valid;
  assign RAM_WPAGE = fifo_out[19:16];
  assign RAM_WCOL = fifo_out[15:8];
  assign RAM_WDATA = fifo_out[7:0];

  // ****************************************
  // instruction execution
  // ****************************************
  reg [2:0] st_q;
  reg mrd_q;
  reg [7:0] col_save_q;
  reg [7:0] latch_q;
  reg bias_q;
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      hcnt_q <= 8'h00;
      icnt_q <= 8'h00;
      rd_pend_q <= 1'b0;
      st_q <= ST_IDLE;
      mrd_q <= 1'b0;
      col_save_q <= 8'h00;
      latch_q <= 8'h00;
      bias_q <= 1'b0;
      HOST_RDATA <= 8'h00;
      HOST_RVALID <= 1'b0;
      HOST_REJECT <= 1'b0;
      RAM_RE <= 1'b0;
      RAM_RPAGE <= 4'h0;
      RAM_RCOL <= 8'h00;
      DISPLAY_ON <= 1'b0;
      TOP_LINE_SELECT <= 6'h00;
      PAGE_FIELD <= 4'h0;
      COLUMN_FIELD <= 8'h00;
      COLUMN_DRIVER_REVERSE <= 1'b0;
      ROW_SCAN_REVERSE <= 1'b0;
      INVERT_PIXELS <= 1'b0;
      ALL_PIXELS_ON <= 1'b0;
      CONVERTER_ENABLE <= 1'b0;
      REGULATOR_ENABLE <= 1'b0;
      FOLLOWER_ENABLE <= 1'b0;
      REGULATOR_RATIO <= `LCDID_RSEL_RST;
      CONTRAST_LEVEL <= `LCDID_CONTRAST_RST;
      INDICATOR_MODE_ON <= 1'b0;
      INDICATOR_BLINK_CODE <= 2'h0;
      POWER_SAVE_SLEEP <= 1'b0;
      POWER_SAVE_STANDBY <= 1'b0;
      TEST_MODE <= 1'b0;
    end else begin
      HOST_RVALID <= 1'b0;
      HOST_REJECT <= take & ~is_stat & ~accept; // R7
      RAM_RE <= 1'b0;
      if (icnt_q != 8'h00) begin
        icnt_q <= icnt_q - 8'h01;
      end
      if (take & is_stat) begin
        // status always answers, even in reset
        HOST_RDATA <= {busy, ~COLUMN_DRIVER_REVERSE, ~DISPLAY_ON, hrst_busy, 4'h0}; // R6 R8
        HOST_RVALID <= 1'b1;
      end
      if (RAM_RVALID & rd_pend_q) begin
        latch_q <= RAM_RDATA;
        rd_pend_q <= 1'b0;
      end
      if (!hrst_s2_q) begin
        // pin reset: full initialisation, counted from the pin's release
        hcnt_q <= HRST_CYC[7:0];
        st_q <= ST_IDLE;
        mrd_q <= 1'b0;
        DISPLAY_ON <= 1'b0;
        TOP_LINE_SELECT <= 6'h00;
        PAGE_FIELD <= 4'h0;
        COLUMN_FIELD <= 8'h00;
        COLUMN_DRIVER_REVERSE <= 1'b0;
        ROW_SCAN_REVERSE <= 1'b0;
        INVERT_PIXELS <= 1'b0;
        ALL_PIXELS_ON <= 1'b0;
        bias_q <= 1'b0;
        CONVERTER_ENABLE <= 1'b0;
        REGULATOR_ENABLE <= 1'b0;
        FOLLOWER_ENABLE <= 1'b0;
        REGULATOR_RATIO <= `LCDID_RSEL_RST;
        CONTRAST_LEVEL <= `LCDID_CONTRAST_RST;
        INDICATOR_MODE_ON <= 1'b0;
        INDICATOR_BLINK_CODE <= 2'h0;
        POWER_SAVE_SLEEP <= 1'b0;
        POWER_SAVE_STANDBY <= 1'b0;
        TEST_MODE <= 1'b0; // R22
      end else begin
        if (hcnt_q != 8'h00) begin
          hcnt_q <= hcnt_q - 8'h01;
        end
        if (accept & is_wr) begin
          COLUMN_FIELD <= col_next(COLUMN_FIELD); // R5 R17
        end
        if (accept & is_rd) begin
          // answer with the latched byte, refill it from the current address
          HOST_RDATA <= latch_q; // R11
          HOST_RVALID <= 1'b1;
          RAM_RE <= 1'b1;
          RAM_RPAGE <= PAGE_FIELD;
          RAM_RCOL <= COLUMN_FIELD;
          rd_pend_q <= 1'b1;
          if (!mrd_q) begin
            COLUMN_FIELD <= col_next(COLUMN_FIELD); // R11 R17
          end
        end
        if (cmd_ok && st_q == ST_CONTR) begin
          CONTRAST_LEVEL <= b[5:0]; // R23
          st_q <= ST_IDLE;
        end else if (cmd_ok && st_q == ST_IND) begin
          INDICATOR_BLINK_CODE <= b[1:0]; // R24
          st_q <= ST_IDLE;
        end else if (cmd_ok) begin
          if (match(b, `LCDID_OP_DISP, `LCDID_MK_DISP)) begin
            DISPLAY_ON <= b[0]; // R1
          end else if (match(b, `LCDID_OP_LINE, `LCDID_MK_LINE)) begin
            TOP_LINE_SELECT <= b[5:0]; // R2
          end else if (match(b, `LCDID_OP_PAGE, `LCDID_MK_NIB)) begin
            PAGE_FIELD <= b[3:0]; // R3
          end else if (match(b, `LCDID_OP_COLH, `LCDID_MK_NIB)) begin
            COLUMN_FIELD <= {b[3:0], COLUMN_FIELD[3:0]}; // R4
          end else if (match(b, `LCDID_OP_COLL, `LCDID_MK_NIB)) begin
            COLUMN_FIELD <= {COLUMN_FIELD[7:4], b[3:0]}; // R4
          end else if (match(b, `LCDID_OP_SEGD, `LCDID_MK_BIT0)) begin
            COLUMN_DRIVER_REVERSE <= b[0]; // R13
          end else if (match(b, `LCDID_OP_INV, `LCDID_MK_BIT0)) begin
            INVERT_PIXELS <= b[0]; // R14
          end else if (match(b, `LCDID_OP_ALL, `LCDID_MK_BIT0)) begin
            ALL_PIXELS_ON <= b[0]; // R15
            if (b[0] & ~DISPLAY_ON) begin
              POWER_SAVE_SLEEP <= ~INDICATOR_MODE_ON; // R25
              POWER_SAVE_STANDBY <= INDICATOR_MODE_ON; // R25
            end else if (!b[0]) begin
              POWER_SAVE_SLEEP <= 1'b0; // R25
              POWER_SAVE_STANDBY <= 1'b0;
            end
          end else if (match(b, `LCDID_OP_BIAS, `LCDID_MK_BIT0)) begin
            bias_q <= b[0]; // R16
          end else if (match(b, `LCDID_OP_MRD, `LCDID_MK_ALL)) begin
            mrd_q <= 1'b1;
            col_save_q <= COLUMN_FIELD; // R18
          end else if (match(b, `LCDID_OP_MRDEND, `LCDID_MK_ALL)) begin
            if (mrd_q) begin
              COLUMN_FIELD <= col_save_q; // R18
            end
            mrd_q <= 1'b0;
          end else if (match(b, `LCDID_OP_RST, `LCDID_MK_ALL)) begin
            // converter, regulator and follower enables and ram are left alone
            icnt_q <= IRST_CYC[7:0]; // R26
            mrd_q <= 1'b0;
            st_q <= ST_IDLE;
            TOP_LINE_SELECT <= 6'h00; // R19
            COLUMN_FIELD <= 8'h00;
            PAGE_FIELD <= 4'h0;
            ROW_SCAN_REVERSE <= 1'b0;
            REGULATOR_RATIO <= `LCDID_RSEL_RST;
            CONTRAST_LEVEL <= `LCDID_CONTRAST_RST;
            INDICATOR_MODE_ON <= 1'b0;
            INDICATOR_BLINK_CODE <= 2'h0;
            TEST_MODE <= 1'b0; // R22
            if (POWER_SAVE_STANDBY) begin
              POWER_SAVE_STANDBY <= 1'b0;
              POWER_SAVE_SLEEP <= 1'b1;
            end
          end else if (match(b, `LCDID_OP_SCAN, `LCDID_MK_NIB)) begin
            ROW_SCAN_REVERSE <= b[3]; // R20
          end else if (match(b, `LCDID_OP_PWR, `LCDID_MK_LOW3)) begin
            CONVERTER_ENABLE <= b[2]; // R21
            REGULATOR_ENABLE <= b[1];
            FOLLOWER_ENABLE <= b[0];
          end else if (match(b, `LCDID_OP_RSEL, `LCDID_MK_LOW3)) begin
            REGULATOR_RATIO <= b[2:0];
          end else if (match(b, `LCDID_OP_CONTR, `LCDID_MK_ALL)) begin
            st_q <= ST_CONTR; // R23
          end else if (match(b, `LCDID_OP_IND, `LCDID_MK_BIT0)) begin
            INDICATOR_MODE_ON <= b[0]; // R24
            if (b[0]) begin
              st_q <= ST_IND;
            end
          end else if (match(b, `LCDID_OP_TEST1, `LCDID_MK_NIB) |
                       match(b, `LCDID_OP_TEST2, `LCDID_MK_NIB)) begin
            TEST_MODE <= 1'b1; // R22
          end
          // nop and unknown codes fall through untouched R22 R27
        end
      end
    end
  end

  // ****************************************
  // derived display outputs
  // ****************************************
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      PIXEL_INVERT_EFFECTIVE <= 1'b0;
      BIAS_DENOMINATOR <= 4'h9;
    end else begin
      PIXEL_INVERT_EFFECTIVE <= INVERT_PIXELS & ~ALL_PIXELS_ON; // R15
      case (duty_s2_q) // R16
        2'h0: BIAS_DENOMINATOR <= bias_q ? 4'h5 : 4'h6;
        2'h1: BIAS_DENOMINATOR <= bias_q ? 4'h6 : 4'h8;
        2'h2: BIAS_DENOMINATOR <= bias_q ? 4'h6 : 4'h8;
        default: BIAS_DENOMINATOR <= bias_q ? 4'h7 : 4'h9;
      endcase
    end
  end
endmodule // lcdid_decoder

/* verification/lcdid_monitor.sv */
// checker: host port answers and display state of the instruction decoder
// assumes it is bound into lcdid_decoder and sees only its ports
`timescale 1ns/1ps
module lcdid_monitor (
  // clock and reset
  input wire CLOCK,
  input wire RESETN,
  // host port
  input wire HARD_RESET_LOW,
  input wire HOST_REQ,
  input wire COMMAND_DATA_SELECT,
  input wire READ_SELECT,
  input wire SERIAL_MODE,
  input wire [7:0] HOST_WDATA,
  input wire [7:0] HOST_RDATA,
  input wire HOST_RVALID,
  input wire HOST_REJECT,
  input wire HOST_BUSY,
  // display state
  input wire DISPLAY_ON,
  input wire [5:0] TOP_LINE_SELECT,
  input wire [3:0] PAGE_FIELD,
  input wire [7:0] COLUMN_FIELD,
  input wire COLUMN_DRIVER_REVERSE,
  input wire ROW_SCAN_REVERSE,
  input wire ALL_PIXELS_ON,
  input wire PIXEL_INVERT_EFFECTIVE
);
  wire stat_rd = HOST_REQ && !COMMAND_DATA_SELECT && READ_SELECT;
  wire cmd_ok = HOST_REQ && !HOST_BUSY && !COMMAND_DATA_SELECT && !READ_SELECT;
  wire wr_ok = HOST_REQ && !HOST_BUSY && COMMAND_DATA_SELECT && !READ_SELECT;
  // second byte of a two-byte command is data, not an opcode
  reg two_q;
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN)
      two_q <= 1'b0;
    else if (cmd_ok)
      two_q <= !two_q && (HOST_WDATA == 8'h81 || HOST_WDATA == 8'had);
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  // ****************
  // named steps
  // ****************
  sequence pin_low;
    !HARD_RESET_LOW [*3];
  endsequence
  sequence rst_clear;
    TOP_LINE_SELECT == 6'h00 && COLUMN_FIELD == 8'h00 && PAGE_FIELD == 4'h0 && !ROW_SCAN_REVERSE;
  endsequence
  sequence busy_run;
    HOST_BUSY [*8];
  endsequence
  // ****************
  // assertions
  // ****************
  status_answer_a: assert property (
    stat_rd |=> HOST_RVALID && HOST_RDATA[3:0] == 4'h0) else $error("status answer wrong");
  status_flags_a: assert property (
    stat_rd |=> HOST_RDATA[6] == !$past(COLUMN_DRIVER_REVERSE)
      && HOST_RDATA[5] == !$past(DISPLAY_ON)) else $error("status flags wrong");
  pin_busy_a: assert property (
    pin_low |-> HOST_BUSY) else $error("not busy under reset pin");
  reset_flag_a: assert property (
    pin_low ##0 stat_rd |=> HOST_RDATA[4]) else $error("reset flag clear under reset pin");
  busy_reject_a: assert property (
    HOST_REQ && HOST_BUSY && !stat_rd |=> HOST_REJECT) else $error("busy request not refused");
  serial_read_a: assert property (
    HOST_REQ && COMMAND_DATA_SELECT && READ_SELECT && SERIAL_MODE |=> HOST_REJECT && !HOST_RVALID)
    else $error("serial data read answered");
  write_step_a: assert property (
    wr_ok && COLUMN_FIELD < 8'h83 |=> COLUMN_FIELD == $past(COLUMN_FIELD) + 8'h01)
    else $error("column not advanced by write");
  display_cmd_a: assert property (
    cmd_ok && !two_q && HOST_WDATA[7:1] == 7'h57 |=> DISPLAY_ON == $past(HOST_WDATA[0]))
    else $error("display switch wrong");
  all_on_a: assert property (
    ALL_PIXELS_ON |=> !PIXEL_INVERT_EFFECTIVE) else $error("invert not overridden");
  reset_instr_a: assert property (
    cmd_ok && !two_q && HOST_WDATA == 8'he2 |=> rst_clear ##0 busy_run)
    else $error("reset instruction incomplete");
endmodule // lcdid_monitor

bind lcdid_decoder lcdid_monitor mon (.*);

/* verification/lcdid_ram_model.sv */
// behavioural display ram on the decoder's ram port
// assumes one clock; stall holds writes off, reads answer after LAT cycles
`timescale 1ns/1ps
module lcdid_ram_model #(
  parameter [3:0] LAT = 4'h3
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire stall,
  // write side
  input wire we,
  output wire wready,
  input wire [3:0] wpage,
  input wire [7:0] wcol,
  input wire [7:0] wdata,
  // read side
  input wire re,
  input wire [3:0] rpage,
  input wire [7:0] rcol,
  output reg rvalid,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:4095];
  reg [11:0] raddr_q;
  reg [3:0] wait_q;
  assign wready = !stall;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 8'h00;
      raddr_q <= 12'h000;
      wait_q <= 4'h0;
    end else begin
      rvalid <= 1'b0;
      // no stale byte between answers
      rdata <= ~rdata;
      if (we && !stall)
        mem[{wpage, wcol}] <= wdata;
      if (re) begin
        raddr_q <= {rpage, rcol};
        wait_q <= LAT;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
        if (wait_q == 4'h1) begin
          rvalid <= 1'b1;
          rdata <= mem[raddr_q];
        end
      end
    end
  end
endmodule // lcdid_ram_model

/* verification/test_lcd_instruction_decoder.sv */
// testbench: instruction sequences on the host port with expected state
// assumes the ram model on the far side; inputs change at the falling edge
`timescale 1ns/1ps
module test_lcd_instruction_decoder;
  logic CLOCK = 1'b0, RESETN = 1'b0, HARD_RESET_LOW = 1'b0, HOST_REQ = 1'b0, stall = 1'b0;
  logic COMMAND_DATA_SELECT = 1'b0, READ_SELECT = 1'b0, SERIAL_MODE = 1'b0;
  logic [1:0] DUTY_RATIO_PINS = 2'h3;
  logic [7:0] HOST_WDATA = 8'h00;
  logic [7:0] HOST_RDATA, RAM_WCOL, RAM_WDATA, RAM_RCOL, RAM_RDATA, COLUMN_FIELD;
  logic [3:0] RAM_WPAGE, RAM_RPAGE, PAGE_FIELD, BIAS_DENOMINATOR;
  logic [5:0] TOP_LINE_SELECT, CONTRAST_LEVEL;
  logic [2:0] REGULATOR_RATIO;
  logic [1:0] INDICATOR_BLINK_CODE;
  logic HOST_RVALID, HOST_REJECT, HOST_BUSY, RAM_WE, RAM_WREADY, RAM_RE, RAM_RVALID;
  logic DISPLAY_ON, COLUMN_DRIVER_REVERSE, ROW_SCAN_REVERSE, INVERT_PIXELS, ALL_PIXELS_ON;
  logic PIXEL_INVERT_EFFECTIVE, CONVERTER_ENABLE, REGULATOR_ENABLE, FOLLOWER_ENABLE;
  logic INDICATOR_MODE_ON, POWER_SAVE_SLEEP, POWER_SAVE_STANDBY, TEST_MODE;
  logic [3:0] bias_tab [0:7] = '{4'h6, 4'h5, 4'h8, 4'h6, 4'h8, 4'h6, 4'h9, 4'h7};
  int err_count = 0;
  int total_checks = 0;
  lcdid_decoder dut (.*);
  lcdid_ram_model ram (.clk(CLOCK), .rst_n(RESETN), .stall(stall), .we(RAM_WE),
    .wready(RAM_WREADY), .wpage(RAM_WPAGE), .wcol(RAM_WCOL), .wdata(RAM_WDATA), .re(RAM_RE),
    .rpage(RAM_RPAGE), .rcol(RAM_RCOL), .rvalid(RAM_RVALID), .rdata(RAM_RDATA));
  always #4 CLOCK = ~CLOCK;
  // ****************
  // host port tasks
  // ****************
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task chk1(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask
  // request stays high across back-to-back calls
  task req(input logic cds, input logic rd_sel, input logic [7:0] d);
    @(negedge CLOCK);
    HOST_REQ = 1'b1;
    COMMAND_DATA_SELECT = cds;
    READ_SELECT = rd_sel;
    HOST_WDATA = d;
  endtask
  task idle;
    @(negedge CLOCK);
    HOST_REQ = 1'b0;
  endtask
  task cmd(input logic [7:0] d);
    req(1'b0, 1'b0, d);
    idle;
  endtask
  task wait_ready;
    int n;
    n = 0;
    while (HOST_BUSY !== 1'b0 && n < 400) begin
      @(negedge CLOCK);
      n++;
    end
    chk1(HOST_BUSY, 1'b0);
  endtask
  task status(input logic [7:0] exp);
    req(1'b0, 1'b1, 8'h00);
    idle;
    chk1(HOST_RVALID, 1'b1);
    chk(HOST_RDATA, exp);
  endtask
  task rd(output logic [7:0] v);
    req(1'b1, 1'b1, 8'h00);
    idle;
    chk1(HOST_RVALID, 1'b1);
    v = HOST_RDATA;
    wait_ready;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK);
    err_count++;
    give_verdict;
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    logic [7:0] v;
    int i;
    repeat (3) @(negedge CLOCK);
    RESETN = 1'b1;
    repeat (3) @(negedge CLOCK);
    status(8'hf0);
    cmd(8'haf);
    chk1(HOST_REJECT, 1'b1);
    chk({2'h0, CONTRAST_LEVEL}, 8'h20);
    HARD_RESET_LOW = 1'b1;
    wait_ready;
    status(8'h60);
    cmd(8'haf);
    cmd(8'ha1);
    chk1(DISPLAY_ON, 1'b1);
    status(8'h00);
    cmd(8'h7f);
    chk({2'h0, TOP_LINE_SELECT}, 8'h3f);
    cmd(8'hb8);
    chk({4'h0, PAGE_FIELD}, 8'h08);
    cmd(8'h18);
    cmd(8'h02);
    chk(COLUMN_FIELD, 8'h82);
    stall = 1'b1;
    req(1'b1, 1'b0, 8'h11);
    req(1'b1, 1'b0, 8'h22);
    cmd(8'hb2);
    chk(COLUMN_FIELD, 8'h83);
    chk({RAM_WPAGE, 3'h0, RAM_WE}, 8'h81);
    cmd(8'h10);
    cmd(8'h05);
    for (i = 0; i < 6; i++)
      req(1'b1, 1'b0, 8'h30 + i[7:0]);
    idle;
    chk1(HOST_BUSY, 1'b1);
    req(1'b1, 1'b0, 8'h99);
    idle;
    chk1(HOST_REJECT, 1'b1);
    chk(COLUMN_FIELD, 8'h0b);
    stall = 1'b0;
    for (i = 0; i < 50 && RAM_WE !== 1'b0; i++)
      @(negedge CLOCK);
    chk1(RAM_WE, 1'b0);
    cmd(8'h10);
    cmd(8'h05);
    rd(v);
    rd(v);
    chk(v, 8'h30);
    rd(v);
    chk(v, 8'h31);
    chk(COLUMN_FIELD, 8'h08);
    cmd(8'he0);
    rd(v);
    rd(v);
    chk(v, 8'h33);
    chk(COLUMN_FIELD, 8'h08);
    req(1'b1, 1'b0, 8'h77);
    idle;
    chk(COLUMN_FIELD, 8'h09);
    cmd(8'hee);
    chk(COLUMN_FIELD, 8'h08);
    SERIAL_MODE = 1'b1;
    req(1'b1, 1'b1, 8'h00);
    idle;
    chk1(HOST_REJECT, 1'b1);
    SERIAL_MODE = 1'b0;
    cmd(8'ha7);
    @(negedge CLOCK);
    chk1(PIXEL_INVERT_EFFECTIVE, 1'b1);
    cmd(8'ha5);
    @(negedge CLOCK);
    chk({INVERT_PIXELS, ALL_PIXELS_ON, PIXEL_INVERT_EFFECTIVE}, 8'h06);
    cmd(8'hae);
    cmd(8'ha5);
    chk1(POWER_SAVE_SLEEP, 1'b1);
    cmd(8'had);
    cmd(8'h02);
    cmd(8'h2d);
    chk({INDICATOR_MODE_ON, INDICATOR_BLINK_CODE}, 8'h06);
    chk({CONVERTER_ENABLE, REGULATOR_ENABLE, FOLLOWER_ENABLE}, 8'h05);
    cmd(8'ha4);
    chk1(POWER_SAVE_SLEEP, 1'b0);
    cmd(8'ha5);
    chk1(POWER_SAVE_STANDBY, 1'b1);
    cmd(8'h81);
    cmd(8'h3f);
    cmd(8'h01);
    chk({2'h0, CONTRAST_LEVEL}, 8'h3f);
    for (i = 0; i < 8; i++) begin
      DUTY_RATIO_PINS = i[2:1];
      cmd(8'ha2 | {7'h00, i[0]});
      repeat (3) @(negedge CLOCK);
      chk({4'h0, BIAS_DENOMINATOR}, {4'h0, bias_tab[i]});
    end
    cmd(8'hcf);
    chk1(ROW_SCAN_REVERSE, 1'b1);
    cmd(8'hf3);
    cmd(8'he3);
    cmd(8'he8);
    chk1(TEST_MODE, 1'b1);
    chk({PAGE_FIELD, COLUMN_FIELD[3:0]}, 8'h21);
    cmd(8'h21);
    chk({5'h00, REGULATOR_RATIO}, 8'h01);
    cmd(8'he2);
    chk({5'h00, REGULATOR_RATIO}, 8'h04);
    chk({2'h0, CONTRAST_LEVEL}, 8'h20);
    chk({TOP_LINE_SELECT, ROW_SCAN_REVERSE, TEST_MODE}, 8'h00);
    chk({PAGE_FIELD, COLUMN_FIELD[3:0]}, 8'h00);
    chk({CONVERTER_ENABLE, FOLLOWER_ENABLE, POWER_SAVE_SLEEP}, 8'h07);
    status(8'ha0);
    cmd(8'haf);
    chk1(HOST_REJECT, 1'b1);
    wait_ready;
    // second test code group must latch too
    cmd(8'h95);
    chk1(TEST_MODE, 1'b1);
    give_verdict;
  end
endmodule // test_lcd_instruction_decoder
